// *** shared/bus_event_point_detector_map.vh ***
`ifndef BUS_EVENT_POINT_DETECTOR_MAP_VH
`define BUS_EVENT_POINT_DETECTOR_MAP_VH

// ======================================================
// Channel counts and register layout
`define SEQ_CH_COUNT 8
`define ALL_CH_COUNT 12
`define TRIG_CH_INDEX 7
// Channel block: byte address = channel * 0x20 + offset * 4
`define CH_STRIDE_SHIFT 5
`define OFF_CTRL 3'h0
`define OFF_ADDR_LO 3'h1
`define OFF_ADDR_HI 3'h2
`define OFF_DATA 3'h3
`define OFF_MASK 3'h4
`define OFF_PASS 3'h5
`define OFF_SEQ 3'h6
// Global registers (word index 7 bits)
`define IDX_DELAY 7'h60
`define IDX_TIMER 7'h61
`define IDX_STATUS 7'h62

// ======================================================
// Channel control fields
`define F_AMODE_MSB 1
`define F_AMODE_LSB 0
`define F_OUTSIDE 2
`define F_DCMP 3
`define F_MASK_EN 4
`define F_SIZE_WORD 5
`define F_DIR_MSB 7
`define F_DIR_LSB 6
`define F_BUS_DC 8
`define F_AREA_DC 9
`define F_ACT_MSB 11
`define F_ACT_LSB 10
`define F_TRACE 12
`define F_ENABLE 13
`define F_SWBRK 14
`define F_SEQ_EN 15
`define F_PROBE_MSB 23
`define F_PROBE_LSB 16
`define F_BUS_MSB 26
`define F_BUS_LSB 24
`define F_AREA_MSB 30
`define F_AREA_LSB 28
// Sequencing register fields
`define F_ARM_MSB 11
`define F_ARM_LSB 0
`define F_ARM_INV 12
`define F_RST_MSB 27
`define F_RST_LSB 16
// Delay register fields
`define F_DLY_MSB 15
`define F_DLY_LSB 0
`define F_DLY_CH_MSB 19
`define F_DLY_CH_LSB 16

// ======================================================
// Encodings and reset values
`define AMODE_ANY 2'h0
`define AMODE_SINGLE 2'h1
`define AMODE_RANGE 2'h2
`define DIR_EITHER 2'h0
`define DIR_READ 2'h1
`define DIR_WRITE 2'h2
`define ACT_BREAK 2'h0
`define ACT_START 2'h1
`define ACT_STOP 2'h2
`define PROBE_HIGH 2'h1
`define PROBE_LOW 2'h2
`define RESET_WORD 32'h0000_0000

`endif

// *** hw/bus_event_point_detector.v ***
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`include "bus_event_point_detector_map.vh"

module bus_event_point_detector #(
  parameter AW = 24,
  parameter DW = 16,
  parameter TW = 32
) (
  input wire mclk_i,
  input wire reset_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output wire hreadyout_o,
  output wire hresp_o,
  output wire [31:0] hrdata_o,
  input wire target_running_i,
  input wire bus_valid_i,
  input wire [AW-1:0] bus_addr_i,
  input wire [DW-1:0] bus_data_i,
  input wire bus_write_i,
  input wire bus_word_i,
  input wire bus_fetch_i,
  input wire [2:0] bus_state_i,
  input wire [2:0] bus_area_i,
  input wire [3:0] probe_i,
  output wire break_req_o,
  output wire first_probe_trigger_out_n_o,
  output wire timer_running_o,
  output wire [`ALL_CH_COUNT-1:0] trace_hit_o
);

  // ======================================================
  // Storage
  reg [31:0] ctrl_reg [0:`ALL_CH_COUNT-1];
  reg [31:0] lo_reg [0:`ALL_CH_COUNT-1];
  reg [31:0] hi_reg [0:`ALL_CH_COUNT-1];
  reg [31:0] data_reg [0:`ALL_CH_COUNT-1];
  reg [31:0] mask_reg [0:`ALL_CH_COUNT-1];
  reg [31:0] pass_reg [0:`ALL_CH_COUNT-1];
  reg [31:0] seq_reg [0:`ALL_CH_COUNT-1];
  reg [15:0] cnt_reg [0:`SEQ_CH_COUNT-1];
  reg [31:0] delay_cfg_reg;
  reg [TW-1:0] timer_reg;
  reg timer_run_reg;
  reg [`ALL_CH_COUNT-1:0] sat_reg;
  reg [15:0] dly_cnt_reg;
  reg dly_act_reg;
  reg break_reg;
  reg trig_n_reg;
  reg [`ALL_CH_COUNT-1:0] trace_reg;
  reg [3:0] probe_meta_reg;
  reg [3:0] probe_sync_reg;
  reg wr_pend_reg;
  reg [6:0] wr_idx_reg;
  reg [31:0] hrdata_reg;
  reg hreadyout_reg;
  reg hresp_reg;

  reg [`ALL_CH_COUNT-1:0] hit;
  reg [`ALL_CH_COUNT-1:0] fire;
  reg [`ALL_CH_COUNT-1:0] rst_any;
  reg brk_now;
  reg start_now;
  reg stop_now;
  reg dly_load;
  reg [31:0] rd_data;
  reg [31:0] c;
  reg evt;
  reg raw;
  reg armed;
  reg [15:0] tgt;
  reg [DW-1:0] m;
  reg [3:0] dly_ch;
  integer i;
  integer j;
  integer k;
  integer r;

  wire addr_phase = hsel_i & htrans_i[1] & hready_i;
  wire addr_mapped = (haddr_i[31:9] == 23'h0) && (haddr_i[1:0] == 2'h0);
  wire [3:0] wr_ch = wr_idx_reg[6:3];
  wire [2:0] wr_off = wr_idx_reg[2:0];

  assign hreadyout_o = hreadyout_reg;
  assign hresp_o = hresp_reg;
  assign hrdata_o = hrdata_reg;
  assign break_req_o = break_reg;
  assign first_probe_trigger_out_n_o = trig_n_reg;
  assign timer_running_o = timer_run_reg;
  assign trace_hit_o = trace_reg;

  // ======================================================
  // Match helpers
  function addr_ok;
    input [1:0] mode;
    input outside;
    input [AW-1:0] lo;
    input [AW-1:0] hi;
    input [AW-1:0] a;
    reg in_r;
    begin
      case (mode)
        `AMODE_SINGLE: in_r = (a == lo);
        `AMODE_RANGE: in_r = (a >= lo) && (a <= hi);
        default: in_r = 1'b1;
      endcase
      addr_ok = (mode != `AMODE_ANY && outside) ? ~in_r : in_r;
    end
  endfunction

  function probe_ok;
    input [7:0] cfg;
    input [3:0] p;
    integer n;
    begin
      probe_ok = 1'b1;
      for (n = 0; n < 4; n = n + 1) begin
        if (cfg[2*n+:2] == `PROBE_HIGH && !p[n]) begin
          probe_ok = 1'b0;
        end
        if (cfg[2*n+:2] == `PROBE_LOW && p[n]) begin
          probe_ok = 1'b0;
        end
      end
    end
  endfunction

  // ======================================================
  // Probe synchroniser
  always @(posedge mclk_i) begin
    if (reset_i) begin
      probe_meta_reg <= 4'h0;
      probe_sync_reg <= 4'h0;
    end else begin
      probe_meta_reg <= probe_i;
      probe_sync_reg <= probe_meta_reg;
    end
  end

  // ======================================================
  // Channel match evaluation
  always @* begin
    hit = {`ALL_CH_COUNT{1'b0}};
    fire = {`ALL_CH_COUNT{1'b0}};
    rst_any = {`ALL_CH_COUNT{1'b0}};
    c = 32'h0;
    evt = 1'b0;
    raw = 1'b0;
    armed = 1'b1;
    tgt = 16'h0;
    m = {DW{1'b1}};
    for (i = 0; i < `ALL_CH_COUNT; i = i + 1) begin
      c = ctrl_reg[i];
      evt = (i < `SEQ_CH_COUNT);
      m = c[`F_MASK_EN] ? mask_reg[i][DW-1:0] : {DW{1'b1}};
      if (c[`F_SWBRK]) begin
        raw = bus_fetch_i && (bus_addr_i == lo_reg[i][AW-1:0]);
      end else begin
        raw = addr_ok(c[`F_AMODE_MSB:`F_AMODE_LSB], c[`F_OUTSIDE] & evt,
                      lo_reg[i][AW-1:0], hi_reg[i][AW-1:0], bus_addr_i)
          && (!c[`F_DCMP] || (((bus_data_i & m) == (data_reg[i][DW-1:0] & m))
                              && (c[`F_SIZE_WORD] == bus_word_i)))
          && (c[`F_DIR_MSB:`F_DIR_LSB] != `DIR_READ || !bus_write_i)
          && (c[`F_DIR_MSB:`F_DIR_LSB] != `DIR_WRITE || bus_write_i)
          && (c[`F_BUS_DC] || bus_state_i == c[`F_BUS_MSB:`F_BUS_LSB])
          && (c[`F_AREA_DC] || bus_area_i == c[`F_AREA_MSB:`F_AREA_LSB])
          && probe_ok(c[`F_PROBE_MSB:`F_PROBE_LSB], probe_sync_reg);
      end
      armed = 1'b1;
      if (evt && c[`F_SEQ_EN] && seq_reg[i][`F_ARM_MSB:`F_ARM_LSB] != 12'h0) begin
        if (seq_reg[i][`F_ARM_INV]) begin
          armed = |(seq_reg[i][`F_ARM_MSB:`F_ARM_LSB] & ~sat_reg);
        end else begin
          armed = |(seq_reg[i][`F_ARM_MSB:`F_ARM_LSB] & sat_reg);
        end
      end
      hit[i] = c[`F_ENABLE] && bus_valid_i && target_running_i && raw && armed
               && !sat_reg[i];
      tgt = (pass_reg[i][15:0] == 16'h0) ? 16'h1 : pass_reg[i][15:0];
      if (evt) begin
        fire[i] = hit[i] && ({1'b0, cnt_reg[i]} + 17'h1 >= {1'b0, tgt});
      end else begin
        fire[i] = hit[i];
      end
    end
    for (i = 0; i < `SEQ_CH_COUNT; i = i + 1) begin
      if (ctrl_reg[i][`F_SEQ_EN]) begin
        rst_any[i] = |(seq_reg[i][`F_RST_MSB:`F_RST_LSB] & fire);
      end
    end
  end

  // ======================================================
  // Action decode
  always @* begin
    brk_now = 1'b0;
    start_now = 1'b0;
    stop_now = 1'b0;
    dly_load = 1'b0;
    dly_ch = delay_cfg_reg[`F_DLY_CH_MSB:`F_DLY_CH_LSB];
    for (j = 0; j < `ALL_CH_COUNT; j = j + 1) begin
      if (fire[j] && !ctrl_reg[j][`F_TRACE]) begin
        if (j >= `SEQ_CH_COUNT
            || ctrl_reg[j][`F_ACT_MSB:`F_ACT_LSB] == `ACT_BREAK) begin
          if (dly_ch == j[3:0] && delay_cfg_reg[`F_DLY_MSB:`F_DLY_LSB] != 16'h0) begin
            dly_load = 1'b1;
          end else begin
            brk_now = 1'b1;
          end
        end else if (ctrl_reg[j][`F_ACT_MSB:`F_ACT_LSB] == `ACT_START) begin
          start_now = 1'b1;
        end else if (ctrl_reg[j][`F_ACT_MSB:`F_ACT_LSB] == `ACT_STOP) begin
          stop_now = 1'b1;
        end
      end
    end
  end

  // ======================================================
  // Channel state, pass counters, outputs
  always @(posedge mclk_i) begin
    if (reset_i) begin
      sat_reg <= {`ALL_CH_COUNT{1'b0}};
      for (k = 0; k < `SEQ_CH_COUNT; k = k + 1) begin
        cnt_reg[k] <= 16'h0;
      end
      dly_cnt_reg <= 16'h0;
      dly_act_reg <= 1'b0;
      break_reg <= 1'b0;
      trig_n_reg <= 1'b1;
      trace_reg <= {`ALL_CH_COUNT{1'b0}};
      timer_run_reg <= 1'b0;
    end else begin
      trig_n_reg <= ~fire[`TRIG_CH_INDEX];
      for (k = 0; k < `ALL_CH_COUNT; k = k + 1) begin
        trace_reg[k] <= fire[k] & ctrl_reg[k][`F_TRACE];
      end
      if (!target_running_i) begin
        sat_reg <= {`ALL_CH_COUNT{1'b0}};
        for (k = 0; k < `SEQ_CH_COUNT; k = k + 1) begin
          cnt_reg[k] <= 16'h0;
        end
        dly_act_reg <= 1'b0;
        dly_cnt_reg <= 16'h0;
        break_reg <= 1'b0;
      end else begin
        for (k = 0; k < `ALL_CH_COUNT; k = k + 1) begin
          if (rst_any[k]) begin
            sat_reg[k] <= 1'b0;
          end else if (fire[k]) begin
            sat_reg[k] <= 1'b1;
          end
        end
        for (k = 0; k < `SEQ_CH_COUNT; k = k + 1) begin
          if (rst_any[k]) begin
            cnt_reg[k] <= 16'h0;
          end else if (hit[k] && !fire[k]) begin
            cnt_reg[k] <= cnt_reg[k] + 16'h1;
          end
        end
        if (dly_load && !dly_act_reg) begin
          dly_act_reg <= 1'b1;
          dly_cnt_reg <= delay_cfg_reg[`F_DLY_MSB:`F_DLY_LSB];
        end else if (dly_act_reg) begin
          dly_cnt_reg <= dly_cnt_reg - 16'h1;
          if (dly_cnt_reg == 16'h1) begin
            dly_act_reg <= 1'b0;
          end
        end
        if (brk_now || (dly_act_reg && dly_cnt_reg == 16'h1)) begin
          break_reg <= 1'b1;
        end
      end
      if (stop_now) begin
        timer_run_reg <= 1'b0;
      end else if (start_now) begin
        timer_run_reg <= 1'b1;
      end
    end
  end

  // ======================================================
  // Register read mux
  always @* begin
    rd_data = 32'h0;
    if (addr_mapped) begin
      if (haddr_i[8:5] < `ALL_CH_COUNT) begin
        case (haddr_i[4:2])
          `OFF_CTRL: rd_data = ctrl_reg[haddr_i[8:5]];
          `OFF_ADDR_LO: rd_data = lo_reg[haddr_i[8:5]];
          `OFF_ADDR_HI: rd_data = hi_reg[haddr_i[8:5]];
          `OFF_DATA: rd_data = data_reg[haddr_i[8:5]];
          `OFF_MASK: rd_data = mask_reg[haddr_i[8:5]];
          `OFF_PASS: rd_data = pass_reg[haddr_i[8:5]];
          `OFF_SEQ: rd_data = seq_reg[haddr_i[8:5]];
          default: rd_data = 32'h0;
        endcase
      end else begin
        case (haddr_i[8:2])
          `IDX_DELAY: rd_data = delay_cfg_reg;
          `IDX_TIMER: rd_data = timer_reg;
          `IDX_STATUS: rd_data = {18'h0, dly_act_reg, timer_run_reg, sat_reg};
          default: rd_data = 32'h0;
        endcase
      end
    end
  end

  // ======================================================
  // AHB-Lite slave and register writes
  always @(posedge mclk_i) begin
    if (reset_i) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 7'h0;
      hrdata_reg <= 32'h0;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
      delay_cfg_reg <= `RESET_WORD;
      timer_reg <= {TW{1'b0}};
      for (r = 0; r < `ALL_CH_COUNT; r = r + 1) begin
        ctrl_reg[r] <= `RESET_WORD;
        lo_reg[r] <= `RESET_WORD;
        hi_reg[r] <= `RESET_WORD;
        data_reg[r] <= `RESET_WORD;
        mask_reg[r] <= `RESET_WORD;
        pass_reg[r] <= `RESET_WORD;
        seq_reg[r] <= `RESET_WORD;
      end
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
      wr_pend_reg <= addr_phase & hwrite_i & addr_mapped;
      if (addr_phase) begin
        wr_idx_reg <= haddr_i[8:2];
      end
      if (addr_phase && !hwrite_i) begin
        hrdata_reg <= rd_data;
      end
      if (wr_pend_reg && wr_idx_reg == `IDX_TIMER) begin
        timer_reg <= hwdata_i[TW-1:0];
      end else if (timer_run_reg) begin
        timer_reg <= timer_reg + {{(TW-1){1'b0}}, 1'b1};
      end
      if (wr_pend_reg && wr_idx_reg == `IDX_DELAY) begin
        delay_cfg_reg <= {12'h0, hwdata_i[`F_DLY_CH_MSB:0]};
      end
      if (wr_pend_reg && wr_ch < `ALL_CH_COUNT) begin
        case (wr_off)
          `OFF_CTRL: ctrl_reg[wr_ch] <= hwdata_i;
          `OFF_ADDR_LO: lo_reg[wr_ch] <= hwdata_i;
          `OFF_ADDR_HI: hi_reg[wr_ch] <= hwdata_i;
          `OFF_DATA: data_reg[wr_ch] <= hwdata_i;
          `OFF_MASK: mask_reg[wr_ch] <= hwdata_i;
          `OFF_PASS: pass_reg[wr_ch] <= {16'h0, hwdata_i[15:0]};
          `OFF_SEQ: seq_reg[wr_ch] <= hwdata_i;
          default: ctrl_reg[wr_ch] <= ctrl_reg[wr_ch];
        endcase
      end
    end
  end

endmodule // bus_event_point_detector

// *** bench/bus_event_point_detector_properties.sv ***
`timescale 1ns/100ps
`include "bus_event_point_detector_map.vh"
module bus_event_point_detector_properties (
  input wire mclk_i,
  input wire reset_i,
  input wire target_running_i,
  input wire bus_valid_i,
  input wire hreadyout_o,
  input wire hresp_o,
  input wire break_req_o,
  input wire first_probe_trigger_out_n_o,
  input wire timer_running_o,
  input wire [`ALL_CH_COUNT-1:0] trace_hit_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  property p_trig_cause;
    $fell(first_probe_trigger_out_n_o) |-> $past(bus_valid_i && target_running_i);
  endproperty
  a_trig_cause: assert property (p_trig_cause) else $error("trigger low without bus cycle");
  property p_trig_pulse;
    !first_probe_trigger_out_n_o |=> first_probe_trigger_out_n_o;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger low too long");
  property p_trace_cause;
    (trace_hit_o != 0) |-> $past(bus_valid_i && target_running_i);
  endproperty
  a_trace_cause: assert property (p_trace_cause) else $error("trace hit without bus cycle");
  property p_trace_once;
    (trace_hit_o & $past(trace_hit_o)) == 0;
  endproperty
  a_trace_once: assert property (p_trace_once) else $error("trace hit repeated");
  property p_timer_cause;
    $rose(timer_running_o) |-> $past(bus_valid_i && target_running_i);
  endproperty
  a_timer_cause: assert property (p_timer_cause) else $error("timer start without bus cycle");
  property p_break_hold;
    break_req_o && target_running_i |=> break_req_o;
  endproperty
  a_break_hold: assert property (p_break_hold) else $error("break dropped while running");
  property p_stop_clear;
    !target_running_i |=> !break_req_o;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("break kept after stop");
  property p_break_cause;
    $rose(break_req_o) |-> $past(target_running_i);
  endproperty
  a_break_cause: assert property (p_break_cause) else $error("break raised while stopped");
  property p_bus_okay;
    hreadyout_o && !hresp_o;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("register bus not ready or error");
endmodule // bus_event_point_detector_properties
bind bus_event_point_detector bus_event_point_detector_properties chk (.*);

// *** bench/monitored_bus_model.sv ***
`timescale 1ns/100ps
module monitored_bus_model (
  input wire mclk_i,
  output logic bus_valid_o,
  output logic [23:0] bus_addr_o,
  output logic [15:0] bus_data_o,
  output logic [8:0] bus_kind_o,
  output logic [3:0] probe_o
);
  initial begin
    bus_valid_o = 1'b0;
    bus_addr_o = 24'h0;
    bus_data_o = 16'h0;
    bus_kind_o = 9'h0;
    probe_o = 4'h0;
  end
  // ==========================================
  // One bus cycle; kind is {area, state, fetch, word, write}
  task cyc(input [23:0] a, input [15:0] d, input [8:0] k);
    @(posedge mclk_i);
    bus_valid_o <= 1'b1;
    bus_addr_o <= a;
    bus_data_o <= d;
    bus_kind_o <= k;
    @(posedge mclk_i);
    bus_valid_o <= 1'b0;
    bus_addr_o <= ~a;
    bus_data_o <= ~d;
    bus_kind_o <= ~k;
  endtask
  // Probes settle past the two-flop lag
  task prb(input [3:0] p);
    @(posedge mclk_i);
    probe_o <= p;
    repeat (3) @(posedge mclk_i);
  endtask
endmodule // monitored_bus_model

// *** bench/bus_event_point_detector_test.sv ***
`timescale 1ns/100ps
module bus_event_point_detector_test;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected %0t %h %h", $time, a, b); end end
  logic mclk_i = 1'b0, reset_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0, target_running_i = 1'b1;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, v, w;
  wire hready_i, hreadyout_o, hresp_o, break_req_o, first_probe_trigger_out_n_o, timer_running_o;
  wire bus_valid_i, bus_write_i, bus_word_i, bus_fetch_i;
  wire [31:0] hrdata_o;
  wire [23:0] bus_addr_i;
  wire [15:0] bus_data_i;
  wire [2:0] bus_state_i, bus_area_i;
  wire [3:0] probe_i;
  wire [11:0] trace_hit_o;
  int miscompares = 0, n_checks = 0, cycles = 0;
  assign hready_i = hreadyout_o;
  bus_event_point_detector dut (.*);
  monitored_bus_model p (.mclk_i(mclk_i), .bus_valid_o(bus_valid_i), .bus_addr_o(bus_addr_i),
    .bus_data_o(bus_data_i), .probe_o(probe_i),
    .bus_kind_o({bus_area_i, bus_state_i, bus_fetch_i, bus_word_i, bus_write_i}));
  initial forever #5 mclk_i = ~mclk_i;
  task complete_run;
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run;
    end
  end
  // ==========================================
  // Register bus and monitored bus helpers
  task xfer(input wr_en, input [31:0] a, d, output [31:0] q);
    @(posedge mclk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= wr_en;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    q = hrdata_o;
  endtask
  task wr(input [31:0] a, d);
    xfer(1'b1, a, d, w);
  endtask
  task cfg(input [3:0] c, input [31:0] k, lo, hi);
    wr({23'h0, c, 5'h04}, lo);
    wr({23'h0, c, 5'h08}, hi);
    wr({23'h0, c, 5'h00}, k);
  endtask
  task hit(input [23:0] a, input [15:0] d, input [8:0] k, input e);
    p.cyc(a, d, k);
    #1 `CHK(break_req_o, e)
  endtask
  task rst;
    @(posedge mclk_i);
    reset_i <= 1'b1;
    @(posedge mclk_i);
    reset_i <= 1'b0;
  endtask
  // ==========================================
  // Scenarios
  initial begin
    repeat (5) @(posedge mclk_i);
    reset_i <= 1'b0;
    #1 `CHK({hreadyout_o, hresp_o, break_req_o, first_probe_trigger_out_n_o, timer_running_o}, 5'h12)
    xfer(0, 32'h0, 0, v); `CHK(v, 32'h0)
    wr(32'h14, 32'hffff_ffff); xfer(0, 32'h14, 0, v); `CHK(v, 32'h0000_ffff)
    wr(32'h180, 32'hffff_ffff); xfer(0, 32'h180, 0, v); `CHK(v, 32'h000f_ffff)
    wr(32'h160, 32'h2301); xfer(0, 32'h160, 0, v); `CHK(v, 32'h2301)
    wr(32'h200, 32'h1); xfer(0, 32'h200, 0, v); `CHK(v, 32'h0)
    rst; cfg(0, 32'h2301, 32'h100, 0);
    hit(24'h104, 0, 0, 0); hit(24'h100, 0, 0, 1);
    @(posedge mclk_i) target_running_i <= 1'b0;
    @(posedge mclk_i) target_running_i <= 1'b1;
    #1 `CHK(break_req_o, 1'b0)
    hit(24'h100, 0, 0, 1);
    rst; cfg(1, 32'h2306, 32'h100, 32'h1ff); hit(24'h150, 0, 0, 0); hit(24'h300, 0, 0, 1);
    rst; cfg(8, 32'h2306, 32'h100, 32'h1ff); hit(24'h300, 0, 0, 0); hit(24'h150, 0, 0, 1);
    rst; cfg(0, 32'h2338, 0, 0); wr(32'h0c, 32'h12ff); wr(32'h10, 32'hff00);
    hit(0, 16'h1234, 9'h000, 0); hit(0, 16'h1334, 9'h002, 0); hit(0, 16'h12aa, 9'h002, 1);
    rst; cfg(0, 32'h2380, 0, 0); hit(0, 0, 9'h000, 0); hit(0, 0, 9'h001, 1);
    rst; cfg(0, 32'h2340, 0, 0); hit(0, 0, 9'h001, 0); hit(0, 0, 9'h000, 1);
    rst; cfg(0, 32'h5300_2000, 0, 0); hit(0, 0, 9'h118, 0); hit(0, 0, 9'h150, 0);
    hit(0, 0, 9'h158, 1);
    rst; cfg(0, 32'h0009_2300, 0, 0); p.prb(4'h3); hit(0, 0, 0, 0);
    p.prb(4'h1); hit(0, 0, 0, 1);
    rst; cfg(0, 32'h2300, 0, 0); wr(32'h14, 32'h3);
    hit(0, 0, 0, 0); hit(0, 0, 0, 0); hit(0, 0, 0, 1);
    rst; wr(32'h134, 32'h3); cfg(9, 32'h2300, 0, 0); hit(0, 0, 0, 1);
    rst; cfg(0, 32'h2300, 0, 0); wr(32'h180, 32'h4); p.cyc(0, 0, 0);
    repeat (3) @(posedge mclk_i);
    #1 `CHK(break_req_o, 1'b0)
    @(posedge mclk_i) #1 `CHK(break_req_o, 1'b1)
    rst; cfg(6, 32'h2300, 0, 0); hit(0, 0, 0, 1); `CHK(first_probe_trigger_out_n_o, 1'b1)
    cfg(7, 32'h2300, 0, 0); p.cyc(0, 0, 0); #1 `CHK(first_probe_trigger_out_n_o, 1'b0)
    @(posedge mclk_i) #1 `CHK(first_probe_trigger_out_n_o, 1'b1)
    rst; cfg(2, 32'h2701, 32'h10, 0); cfg(3, 32'h2b01, 32'h20, 0);
    hit(24'h10, 0, 0, 0); `CHK(timer_running_o, 1'b1)
    xfer(0, 32'h184, 0, v); xfer(0, 32'h184, 0, w); `CHK(w - v, 32'h3)
    hit(24'h20, 0, 0, 0); `CHK(timer_running_o, 1'b0)
    xfer(0, 32'h184, 0, v); xfer(0, 32'h184, 0, w); `CHK(w, v)
    cfg(8, 32'h2701, 32'h30, 0); hit(24'h30, 0, 0, 1); `CHK(timer_running_o, 1'b0)
    rst; cfg(0, 32'h6081, 32'h40, 0); hit(24'h40, 0, 9'h001, 0); hit(24'h40, 0, 9'h144, 1);
    rst; cfg(0, 32'h3300, 0, 0); p.cyc(0, 0, 0); #1 `CHK(trace_hit_o, 12'h001)
    `CHK(break_req_o, 1'b0)
    rst; cfg(0, 32'h2b01, 32'h30, 0); wr(32'h38, 32'h1); cfg(1, 32'ha301, 32'h40, 0);
    hit(24'h40, 0, 0, 0); hit(24'h30, 0, 0, 0); hit(24'h40, 0, 0, 1);
    rst; cfg(0, 32'h2b01, 32'h30, 0); wr(32'h38, 32'h1001); cfg(1, 32'ha301, 32'h40, 0);
    hit(24'h30, 0, 0, 0); hit(24'h40, 0, 0, 0);
    @(posedge mclk_i) target_running_i <= 1'b0;
    @(posedge mclk_i) target_running_i <= 1'b1;
    hit(24'h40, 0, 0, 1);
    rst; cfg(2, 32'h2b01, 32'h50, 0); wr(32'h38, 32'h0004_0000); wr(32'h34, 32'h2);
    cfg(1, 32'ha301, 32'h40, 0); hit(24'h40, 0, 0, 0); hit(24'h50, 0, 0, 0);
    hit(24'h40, 0, 0, 0); hit(24'h40, 0, 0, 1);
    complete_run;
  end
endmodule // bus_event_point_detector_test
